/* design/lsc_pkg.sv */
// Shared constants and types for the LED sink serial/mode control link
package lsc_pkg;

  // ----------------------------------------------------------------
  // Widths and reset values
  // ----------------------------------------------------------------
  localparam int CH_N = 16;
  localparam int CFG_W = 8;
  localparam logic [7:0] CFG_RESET = 8'hff;
  localparam logic [15:0] WORD_RESET = 16'h0000;

  // ----------------------------------------------------------------
  // Timing: 100 MHz core clock, serial edge every SCLK_DIV cycles
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int SCLK_DIV = 4;
  localparam logic [7:0] SCLK_DIV_LAST = 8'h03;
  localparam int DETECT_TIME_NS = 2000;
  localparam int DETECT_CYC = (DETECT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DETECT_EDGES_RAW = (DETECT_CYC + SCLK_DIV - 1) / SCLK_DIV + 1;
  localparam int DETECT_EDGES = (DETECT_EDGES_RAW < 3) ? 3 : DETECT_EDGES_RAW;
  localparam int SEND_EDGES = 16;
  localparam int SWITCH_EDGES = 5;

  // ----------------------------------------------------------------
  // Controller register map and fields
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_OFFS = 8'h00;
  localparam logic [7:0] DATA_OFFS = 8'h04;
  localparam logic [7:0] STAT_OFFS = 8'h08;
  localparam int CTRL_LAMPS_BIT = 8;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_SPECIAL_BIT = 1;
  localparam int STAT_REFUSED_BIT = 2;

  // Controller commands, written to CTRL bits [2:0]
  typedef enum logic [2:0] {
    OP_NONE = 3'h0,
    OP_SEND = 3'h1,
    OP_LATCH = 3'h2,
    OP_TO_SPECIAL = 3'h3,
    OP_TO_NORMAL = 3'h4,
    OP_DETECT = 3'h5
  } lsc_op_e;

  // Driver operating mode
  typedef enum logic [1:0] {
    MODE_NORMAL = 2'b01,
    MODE_SPECIAL = 2'b10
  } lsc_mode_e;

  // Controller sequencer state
  typedef enum logic [1:0] {
    CST_IDLE = 2'b01,
    CST_RUN = 2'b10
  } lsc_cst_e;

endpackage

/* design/lsc_link_if.sv */
// Serial link between the system controller and the LED sink driver
`timescale 1ns/1ps
interface lsc_link_if;
  logic shift_en;
  logic serial_in;
  logic latch_mode_select_line;
  logic enable_detect_n_line;
  logic serial_out;

  modport dev (
    input shift_en,
    input serial_in,
    input latch_mode_select_line,
    input enable_detect_n_line,
    output serial_out
  );

  modport ctl (
    output shift_en,
    output serial_in,
    output latch_mode_select_line,
    output enable_detect_n_line,
    input serial_out
  );
endinterface

/* design/lsc_driver.sv */
// LED sink driver: shift register, latches, mode switching, error capture
`timescale 1ns/1ps
module lsc_driver
  import lsc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  lsc_link_if.dev link,
  input wire logic [15:0] open_flag,
  input wire logic [15:0] short_trip,
  input wire logic [15:0] short_ret_low,
  input wire logic [15:0] chan_ot,
  input wire logic global_ot,
  output logic [15:0] sink_channels,
  output logic [7:0] config_code,
  output logic current_multiplier_bit,
  output logic gain_range_bit,
  output logic [5:0] gain_mantissa_field,
  output logic special_mode
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  lsc_mode_e mode_q;
  logic [15:0] shift_q;
  logic [15:0] out_latch_q;
  logic [7:0] cfg_q;
  logic [1:0] hist_q;
  logic [1:0] sw_cnt_q;
  logic [1:0] low_cnt_q;
  logic [15:0] short_q;
  logic [15:0] ot_q;
  logic [15:0] sink_q;
  logic sout_q;

  // ----------------------------------------------------------------
  // Decode of the link at each serial edge
  // ----------------------------------------------------------------
  // The controller runs on ref_clk, so the link needs no synchroniser.
  wire edge_now = link.shift_en;
  wire oe_n = link.enable_detect_n_line;
  wire le = link.latch_mode_select_line;
  wire is_special = (mode_q == MODE_SPECIAL);
  // High, low, high over three consecutive edges
  wire pulse_seen = edge_now & hist_q[1] & ~hist_q[0] & oe_n;
  wire pick_edge = edge_now & (sw_cnt_q == 2'd2);
  // Latching is blocked from the pulse's closing edge through edge five
  wire latch_block = pulse_seen | (sw_cnt_q != 2'd0);
  wire latch_ok = le & ~latch_block;
  wire to_normal = pick_edge & ~le;
  // Third or later low sample while in Special mode
  wire capture = edge_now & is_special & ~oe_n & (low_cnt_q == 2'd2);
  // A channel counts as on when enabled and its latch bit is set
  wire [15:0] drive_req = {16{~oe_n}} & out_latch_q;
  wire [15:0] status_word = drive_req & ~open_flag & ~short_q & ~ot_q;
  wire [15:0] shift_d = capture ? status_word : {shift_q[14:0], link.serial_in};

  // ----------------------------------------------------------------
  // Mode switching sequence
  // ----------------------------------------------------------------
  // Enable-line history and the switch phase counter
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      hist_q <= 2'b11;
      sw_cnt_q <= 2'd0;
    end
    else if (edge_now)
    begin
      hist_q <= {hist_q[0], oe_n};
      if (pulse_seen)
        sw_cnt_q <= 2'd2;
      else if (sw_cnt_q != 2'd0)
        sw_cnt_q <= sw_cnt_q - 2'd1;
    end
  end

  // Operating mode; power-up always lands in Normal
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      mode_q <= MODE_NORMAL;
    else if (pick_edge)
      mode_q <= le ? MODE_SPECIAL : MODE_NORMAL;
  end

  // ----------------------------------------------------------------
  // Shift path and detection count
  // ----------------------------------------------------------------
  // Shifting continues through a switch; status capture only wins
  // from the third low sample on, so the first two still shift.
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      shift_q <= WORD_RESET;
      low_cnt_q <= 2'd0;
      sout_q <= 1'b0;
    end
    else if (edge_now)
    begin
      shift_q <= shift_d;
      sout_q <= shift_d[15];
      if (oe_n)
        low_cnt_q <= 2'd0;
      else if (low_cnt_q != 2'd2)
        low_cnt_q <= low_cnt_q + 2'd1;
    end
  end

  // ----------------------------------------------------------------
  // Output and configuration latches
  // ----------------------------------------------------------------
  // Transparent while the latch line is high; the target depends on mode
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      out_latch_q <= WORD_RESET;
      cfg_q <= CFG_RESET;
    end
    else if (latch_ok)
    begin
      if (is_special)
        cfg_q <= shift_q[CFG_W-1:0];
      else
        out_latch_q <= shift_q;
    end
  end

  // ----------------------------------------------------------------
  // Fault recording
  // ----------------------------------------------------------------
  // Flags only count while the channel is driven; a new fault in the
  // clearing cycle survives the clear.
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      short_q <= WORD_RESET;
      ot_q <= WORD_RESET;
    end
    else
    begin
      short_q <= (short_q & ~short_ret_low & {16{~to_normal}})
               | (drive_req & short_trip);
      ot_q <= (ot_q & {16{~to_normal}})
            | (drive_req & (chan_ot | {16{global_ot}}));
    end
  end

  // ----------------------------------------------------------------
  // Sink drive
  // ----------------------------------------------------------------
  // Thermal cut is live, so channels restart on cooling if still latched
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      sink_q <= WORD_RESET;
    else
      sink_q <= drive_req & ~chan_ot & ~{16{global_ot}};
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Serial output is registered so cascaded parts see a clean edge
  assign link.serial_out = sout_q;
  assign sink_channels = sink_q;
  assign config_code = cfg_q;
  assign current_multiplier_bit = cfg_q[0];
  assign gain_range_bit = cfg_q[1];
  assign gain_mantissa_field = cfg_q[7:2];
  assign special_mode = mode_q[1];

endmodule

/* design/lsc_ctrl.sv */
// System controller end: register port in, serial sequences out
`timescale 1ns/1ps
module lsc_ctrl
  import lsc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  lsc_link_if.ctl link,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata
);

  // ----------------------------------------------------------------
  // Sequence tables
  // ----------------------------------------------------------------
  // Number of serial edges a command takes
  function automatic logic [7:0] edge_count(input lsc_op_e op);
    case (op)
      OP_SEND: edge_count = 8'(SEND_EDGES);
      OP_LATCH: edge_count = 8'd1;
      OP_TO_SPECIAL: edge_count = 8'(SWITCH_EDGES);
      OP_TO_NORMAL: edge_count = 8'(SWITCH_EDGES);
      OP_DETECT: edge_count = 8'(DETECT_EDGES);
      default: edge_count = 8'd1;
    endcase
  endfunction

  // Pin levels {latch, enable_n, data} for edge k of a command
  function automatic logic [2:0] edge_bits(input lsc_op_e op, input logic [7:0] k,
                                           input logic [15:0] tx, input logic lamps);
    logic [3:0] idx;
    idx = 4'd15 - k[3:0];
    case (op)
      OP_SEND: edge_bits = {1'b0, ~lamps, tx[idx]};
      OP_LATCH: edge_bits = {1'b1, ~lamps, 1'b0};
      // High, low, high, then the mode pick and a quiet fifth edge
      OP_TO_SPECIAL, OP_TO_NORMAL:
        edge_bits = {(k == 8'd3) && (op == OP_TO_SPECIAL), k != 8'd1, 1'b0};
      // Low for the whole run; enable rises only in idle, so no strobe
      // shifts the captured status before SEND reads it back
      OP_DETECT: edge_bits = {1'b0, 1'b0, 1'b0};
      default: edge_bits = {1'b0, ~lamps, 1'b0};
    endcase
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  lsc_cst_e st_q;
  lsc_op_e op_q;
  logic [7:0] k_q;
  logic [7:0] div_q;
  logic [15:0] tx_q;
  logic [15:0] rx_q;
  logic lamps_q;
  logic special_q;
  logic dirty_q;
  logic refused_q;
  logic [2:0] pins_q;
  logic strobe_q;
  logic [31:0] rdata_q;

  // ----------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------
  wire busy = (st_q == CST_RUN);
  wire ctrl_wr = wr & (addr == CTRL_OFFS);
  wire [2:0] op_field = wdata[2:0];
  wire op_valid = (op_field >= 3'h1) && (op_field <= 3'h5);
  lsc_op_e op_new;
  assign op_new = lsc_op_e'(op_field);
  // Captured status must not land in the configuration latch
  wire unsafe = (op_new == OP_LATCH) & special_q & dirty_q;
  wire go = ctrl_wr & op_valid & ~busy & ~unsafe;
  wire strobe_due = busy & (div_q == SCLK_DIV_LAST);
  wire last_edge = (k_q + 8'd1 == edge_count(op_q));

  // ----------------------------------------------------------------
  // Settings and software view
  // ----------------------------------------------------------------
  // Lamp enable and transmit word; a command repeats freely
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      lamps_q <= 1'b0;
      tx_q <= WORD_RESET;
      refused_q <= 1'b0;
    end
    else
    begin
      if (ctrl_wr)
      begin
        lamps_q <= wdata[CTRL_LAMPS_BIT];
        refused_q <= op_valid & ~go;
      end
      if (wr & (addr == DATA_OFFS) & ~busy)
        tx_q <= wdata[15:0];
    end
  end

  // Read data one cycle after the strobe; unmapped reads return zero
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      rdata_q <= 32'h0000_0000;
    else if (rd)
    begin
      case (addr)
        CTRL_OFFS: rdata_q <= {23'h0, lamps_q, 5'h0, op_q};
        DATA_OFFS: rdata_q <= {16'h0, rx_q};
        STAT_OFFS: rdata_q <= {29'h0, refused_q, special_q, busy};
        default: rdata_q <= 32'h0000_0000;
      endcase
    end
    else
      rdata_q <= 32'h0000_0000;
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  // Pins move on the edge at which the driver takes a strobe, so each
  // level stands a full serial period before it is sampled.
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      st_q <= CST_IDLE;
      op_q <= OP_NONE;
      k_q <= 8'd0;
      div_q <= 8'd0;
      pins_q <= 3'b010;
      strobe_q <= 1'b0;
    end
    else
    begin
      strobe_q <= strobe_due;
      case (st_q)
        CST_IDLE:
        begin
          pins_q <= {1'b0, ~lamps_q, 1'b0};
          if (go)
          begin
            st_q <= CST_RUN;
            op_q <= op_new;
            k_q <= 8'd0;
            div_q <= 8'd0;
            pins_q <= edge_bits(op_new, 8'd0, tx_q, lamps_q);
          end
        end
        CST_RUN:
        begin
          div_q <= strobe_due ? 8'd0 : div_q + 8'd1;
          // Idle levels at once, so a latch pulse never outlives its edge
          if (strobe_q & last_edge)
          begin
            st_q <= CST_IDLE;
            pins_q <= {1'b0, ~lamps_q, 1'b0};
          end
          else if (strobe_q)
          begin
            k_q <= k_q + 8'd1;
            pins_q <= edge_bits(op_q, k_q + 8'd1, tx_q, lamps_q);
          end
        end
        default: st_q <= CST_IDLE;
      endcase
    end
  end

  // Shift in what the driver sends back; track mode and stale status
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      rx_q <= WORD_RESET;
      special_q <= 1'b0;
      dirty_q <= 1'b0;
    end
    else if (strobe_due)
    begin
      rx_q <= {rx_q[14:0], link.serial_out};
      if (last_edge & (op_q == OP_TO_SPECIAL))
        special_q <= 1'b1;
      if (last_edge & (op_q == OP_TO_NORMAL))
        special_q <= 1'b0;
      if (last_edge & (op_q == OP_DETECT))
        dirty_q <= 1'b1;
      else if (last_edge & (op_q == OP_SEND))
        dirty_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign link.shift_en = strobe_q;
  assign link.latch_mode_select_line = pins_q[2];
  assign link.enable_detect_n_line = pins_q[1];
  assign link.serial_in = pins_q[0];
  assign rdata = rdata_q;

endmodule

/* test/lsc_link_checker.sv */
// Concurrent checks on the serial link between controller and driver
`timescale 1ns/1ps
module lsc_link_checker
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic shift_en,
  input wire logic serial_in,
  input wire logic latch_mode_select_line,
  input wire logic enable_detect_n_line,
  input wire logic serial_out
);
  logic [15:0] hist_q;
  logic [1:0] low_q;
  logic [4:0] clean_q;
  wire low_now = !enable_detect_n_line;
  wire double_low = low_q[0] && low_now;

  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  // ----------------------------------------------------------------
  // Helper logic
  // ----------------------------------------------------------------
  // Shadow of serial_in per strobe; two lows in a row may load status,
  // so the shadow is trusted only after 16 clean strobes
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      hist_q <= 16'h0000;
      low_q <= 2'h0;
      clean_q <= 5'h00;
    end
    else if (shift_en)
    begin
      hist_q <= {hist_q[14:0], serial_in};
      low_q <= {low_q[0], low_now};
      clean_q <= double_low ? 5'h00 : clean_q + {4'h0, clean_q != 5'h1f};
    end
  end

  // ----------------------------------------------------------------
  // Sequences and properties
  // ----------------------------------------------------------------
  sequence s_pulse;
    (shift_en && !low_now) ##4 (shift_en && low_now) ##4 (shift_en && !low_now);
  endsequence
  property p_strobe_gap;
    shift_en |=> !shift_en [*3];
  endproperty
  property p_pin_setup;
    shift_en |-> $stable(serial_in) && $stable(latch_mode_select_line)
      && $stable(enable_detect_n_line);
  endproperty
  property p_out_hold;
    !shift_en |=> $stable(serial_out);
  endproperty
  property p_reset_idle;
    $fell(rst) |-> enable_detect_n_line && !shift_en && !latch_mode_select_line && !serial_out;
  endproperty
  property p_switch_edges;
    s_pulse |-> ##4 shift_en ##4 shift_en;
  endproperty
  property p_switch_high;
    s_pulse |-> ##4 enable_detect_n_line ##4 enable_detect_n_line;
  endproperty
  property p_detect_run;
    shift_en && low_now && low_q == 2'b01 |-> ##4 (shift_en && low_now);
  endproperty
  property p_shift_through;
    shift_en && clean_q >= 5'h10 |=> serial_out == hist_q[15];
  endproperty

  a_strobe_gap: assert property (p_strobe_gap) else $error("strobe spacing broken");
  a_pin_setup: assert property (p_pin_setup) else $error("pins moved at strobe");
  a_out_hold: assert property (p_out_hold) else $error("serial_out moved unstrobed");
  a_reset_idle: assert property (p_reset_idle) else $error("link not idle at reset");
  a_switch_edges: assert property (p_switch_edges) else $error("switch tail missing");
  a_switch_high: assert property (p_switch_high) else $error("switch tail not high");
  a_detect_run: assert property (p_detect_run) else $error("detect run too short");
  a_shift_through: assert property (p_shift_through) else $error("serial data lost");
endmodule

/* test/tb.sv */
// Self-checking bench joining the controller and driver ends
`timescale 1ns/1ps
module tb
  import lsc_pkg::*;
;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rdata;
  logic [15:0] open_flag = 16'h0000;
  logic [15:0] short_trip = 16'h0000;
  logic [15:0] short_ret_low = 16'hffff;
  logic [15:0] chan_ot = 16'h0000;
  logic global_ot = 1'b0;
  logic [15:0] sink_channels;
  logic [7:0] config_code;
  logic current_multiplier_bit;
  logic gain_range_bit;
  logic [5:0] gain_mantissa_field;
  logic special_mode;
  int n_errors = 0;
  int num_checks = 0;
  int cycles = 0;
  int seed = 32'hf2f7;
  logic [15:0] m_sr;
  logic [15:0] m_lat;
  logic [15:0] tx;
  logic [15:0] st;
  logic [7:0] m_cfg;
  logic [31:0] r;

  // ----------------------------------------------------------------
  // Both ends and the link checker
  // ----------------------------------------------------------------
  lsc_link_if lsc_link_if_i ();
  lsc_ctrl lsc_ctrl_i (.ref_clk(ref_clk), .rst(rst), .link(lsc_link_if_i), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
  // Return comparator dropped during detection so short faults stay sticky
  lsc_driver lsc_driver_i (.ref_clk(ref_clk), .rst(rst), .link(lsc_link_if_i),
    .open_flag(open_flag), .short_trip(short_trip), .short_ret_low(short_ret_low),
    .chan_ot(chan_ot), .global_ot(global_ot), .sink_channels(sink_channels),
    .config_code(config_code), .current_multiplier_bit(current_multiplier_bit),
    .gain_range_bit(gain_range_bit), .gain_mantissa_field(gain_mantissa_field),
    .special_mode(special_mode));
  lsc_link_checker lsc_link_checker_i (.ref_clk(ref_clk), .rst(rst),
    .shift_en(lsc_link_if_i.shift_en), .serial_in(lsc_link_if_i.serial_in),
    .latch_mode_select_line(lsc_link_if_i.latch_mode_select_line),
    .enable_detect_n_line(lsc_link_if_i.enable_detect_n_line),
    .serial_out(lsc_link_if_i.serial_out));

  // ----------------------------------------------------------------
  // Clock, hang guard and tasks
  // ----------------------------------------------------------------
  always #5 ref_clk = ~ref_clk;

  // Whole run needs about a thousand cycles; a stuck busy bit ends here
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      n_errors++;
      print_verdict();
    end
  end

  task print_verdict();
    if (n_errors == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge ref_clk);
    wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge ref_clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask

  task wait_idle();
    for (int i = 0; i < 400; i++)
    begin
      rd_reg(STAT_OFFS, r);
      if (r[STAT_BUSY_BIT] === 1'b0)
        break;
    end
    if (r[STAT_BUSY_BIT] !== 1'b0)
    begin
      n_errors++;
      $display("ERROR %0t: controller stuck busy", $time);
    end
  endtask

  task op(input lsc_op_e o, input logic lamps);
    wr_reg(CTRL_OFFS, {23'h0, lamps, 5'h00, o});
    wait_idle();
  endtask

  task send(input logic [15:0] d, input logic lamps);
    wr_reg(DATA_OFFS, {16'h0, d});
    op(OP_SEND, lamps);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (4) @(posedge ref_clk);
    rst <= 1'b0;
    tick(1);
    chk({24'h0, config_code}, {24'h0, CFG_RESET});
    chk({31'h0, special_mode}, 32'h0);
    rd_reg(8'h0c, r);
    chk(r, 32'h0);
    m_sr = 16'h0000;
    // Two words back to back; the first must come out whole
    for (int k = 0; k < 2; k++)
    begin
      tx = 16'($random(seed));
      send(tx, 1'b1);
      rd_reg(DATA_OFFS, r);
      chk(r, {16'h0, m_sr});
      m_sr = tx;
      chk({16'h0, sink_channels}, 32'h0);
    end
    op(OP_LATCH, 1'b1);
    m_lat = m_sr;
    tick(3);
    chk({16'h0, sink_channels}, {16'h0, m_lat});
    op(OP_NONE, 1'b0);
    tick(3);
    chk({16'h0, sink_channels}, 32'h0);
    op(OP_TO_SPECIAL, 1'b0);
    op(OP_TO_SPECIAL, 1'b0);
    rd_reg(STAT_OFFS, r);
    chk({31'h0, r[STAT_SPECIAL_BIT]}, 32'h1);
    chk({31'h0, special_mode}, 32'h1);
    chk({24'h0, config_code}, {24'h0, CFG_RESET});
    m_cfg = 8'($random(seed));
    send({8'h5a, m_cfg}, 1'b0);
    op(OP_LATCH, 1'b0);
    chk({24'h0, config_code}, {24'h0, m_cfg});
    chk({24'h0, gain_mantissa_field, gain_range_bit, current_multiplier_bit},
      {24'h0, m_cfg});
    // Detection with random comparator flags, lamps on meanwhile
    @(posedge ref_clk);
    open_flag <= 16'($random(seed));
    short_trip <= 16'($random(seed));
    chan_ot <= 16'($random(seed));
    short_ret_low <= 16'h0000;
    wr_reg(CTRL_OFFS, {23'h0, 1'b1, 5'h00, OP_DETECT});
    tick(80);
    chk({16'h0, sink_channels}, {16'h0, m_lat & ~chan_ot});
    wait_idle();
    st = m_lat & ~open_flag & ~short_trip & ~chan_ot;
    @(posedge ref_clk);
    open_flag <= 16'h0000;
    short_trip <= 16'h0000;
    chan_ot <= 16'h0000;
    op(OP_LATCH, 1'b0);
    rd_reg(STAT_OFFS, r);
    chk({31'h0, r[STAT_REFUSED_BIT]}, 32'h1);
    chk({24'h0, config_code}, {24'h0, m_cfg});
    send(16'($random(seed)), 1'b0);
    rd_reg(DATA_OFFS, r);
    chk(r, {16'h0, st});
    op(OP_TO_NORMAL, 1'b0);
    chk({31'h0, special_mode}, 32'h0);
    chk({24'h0, config_code}, {24'h0, m_cfg});
    @(posedge ref_clk);
    short_ret_low <= 16'hffff;
    tx = 16'($random(seed));
    send(tx, 1'b1);
    op(OP_LATCH, 1'b1);
    m_lat = tx;
    tick(3);
    chk({16'h0, sink_channels}, {16'h0, m_lat});
    // Back to Special: earlier faults must be gone
    op(OP_TO_SPECIAL, 1'b0);
    op(OP_DETECT, 1'b0);
    chk({16'h0, sink_channels}, 32'h0);
    send(16'($random(seed)), 1'b0);
    rd_reg(DATA_OFFS, r);
    chk(r, {16'h0, m_lat});
    op(OP_NONE, 1'b1);
    @(posedge ref_clk);
    global_ot <= 1'b1;
    tick(3);
    chk({16'h0, sink_channels}, 32'h0);
    @(posedge ref_clk);
    global_ot <= 1'b0;
    tick(3);
    chk({16'h0, sink_channels}, {16'h0, m_lat});
    print_verdict();
  end
endmodule
